// File: lcdd_pkg.sv
// Shared constants and types of the LCD command decoder
package lcdd_pkg;

   // Command codes and the masks that select their fixed bits
   localparam logic [7:0] MASK_BIT0      = 8'hfe;
   localparam logic [7:0] MASK_TOP2      = 8'hc0;
   localparam logic [7:0] MASK_TOP4      = 8'hf0;
   localparam logic [7:0] MASK_TOP5      = 8'hf8;
   localparam logic [7:0] CMD_DISPLAY    = 8'hae;
   localparam logic [7:0] CMD_START_LINE = 8'h40;
   localparam logic [7:0] CMD_PAGE       = 8'hb0;
   localparam logic [7:0] CMD_COL_HIGH   = 8'h10;
   localparam logic [7:0] CMD_COL_LOW    = 8'h00;
   localparam logic [7:0] CMD_SEG_DIR    = 8'ha0;
   localparam logic [7:0] CMD_INVERT     = 8'ha6;
   localparam logic [7:0] CMD_ALL_ON     = 8'ha4;
   localparam logic [7:0] CMD_BIAS       = 8'ha2;
   localparam logic [7:0] CMD_RMW        = 8'he0;
   localparam logic [7:0] CMD_END        = 8'hee;
   localparam logic [7:0] CMD_SW_RESET   = 8'he2;
   localparam logic [7:0] CMD_NOP        = 8'he3;
   localparam logic [7:0] CMD_COM_DIR    = 8'hc0;
   localparam logic [7:0] CMD_POWER      = 8'h28;
   localparam logic [7:0] CMD_RATIO      = 8'h20;
   localparam logic [7:0] CMD_VOLUME     = 8'h81;
   localparam logic [7:0] CMD_STATIC     = 8'hac;
   localparam logic [7:0] CMD_BOOSTER    = 8'hf8;

   // Status byte layout
   localparam int         STAT_BUSY_BIT  = 7;
   localparam int         STAT_SEG_BIT   = 6;
   localparam int         STAT_OFF_BIT   = 5;
   localparam int         STAT_RST_BIT   = 4;

   // Pin synchroniser: {parallel, hw reset, bus style, cs, select, rd, wr, data}
   localparam int          PIN_W         = 15;
   localparam logic [14:0] PIN_RST       = 15'h4b00;

   // Reset values of the settings
   localparam logic [5:0] RST_START      = 6'h00;
   localparam logic [3:0] RST_PAGE       = 4'h0;
   localparam logic [7:0] RST_COLUMN     = 8'h00;
   localparam logic [2:0] RST_POWER      = 3'h0;
   localparam logic [2:0] RST_RATIO      = 3'h0;
   localparam logic [5:0] RST_VOLUME     = 6'h00;
   localparam logic [1:0] RST_BOOSTER    = 2'h0;

   // Internal reset must finish within this time after release
   localparam int         CLK_PERIOD_NS  = 100;
   localparam int         RESET_MAX_NS   = 1000;
   localparam int         RESET_MAX_CYC  = RESET_MAX_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_VOLUME,
      ST_STATIC,
      ST_BOOSTER
   } lcdd_pend_type;

endpackage

// File: lcdd_decoder.sv
// Command decoder and display RAM access of a dot-matrix LCD controller
`timescale 1ns/1ns

// Function
// R1: Display on/off command bit 0 turns panel output off or on.
// R2: Byte 01xxxxxx loads the display start line from its low six bits.
// R3: Byte 1011xxxx loads the page pointer from its low four bits.
// R4: Bytes 0001xxxx and 0000xxxx load high and low column nibbles.
// R5: Status read returns flags in bits 7..4 and zeros below. The busy bit 7 is always read as 0.
// R6: Data write stores the byte at current page and column.
// R7: Data read drives the RAM byte at current page and column.
// R8: Segment direction command picks normal or reversed column mapping.
// R9: Inversion command shows RAM plain or with every dot inverted.
// R10: All-points command shows RAM or forces every dot on.
// R11: Bias command bit 0 picks one ninth or one seventh bias.
// R12: In read-modify-write, writes advance column, reads do not; end cancels.
// R13: Byte 1100xxxx sets common scan direction from bit 3.
// R14: Byte 00101xxx loads the power supply operating mode.
// R15: Byte 00100xxx loads the regulator resistor ratio.
// R16: Volume command is followed by a byte whose six low bits set contrast.
// R17: Static indicator command bit 0 sets on/off; next byte sets flash mode.
// R18: Booster command is followed by a byte whose two low bits set ratio.
// R19: Display off together with all points on enters power saving.
// R20: Host never sends 1111xxxx bytes other than the booster command.
// R21: Host should initialise with the suggested command sequence.
// R22: Reset is held at least 1 us; internal reset ends within 1 us.
// R23: No-operation command changes no setting or pointer.
// R24: Select line high marks RAM data, low marks commands or status.
// R25: Hardware reset low clears all settings while it stays low.
// R26: In 8080 style the byte is captured on the write strobe rising edge.
// R27: Serial mode allows writes only; host attempts no reads there.
module lcdd_decoder
   import lcdd_pkg::*;
#(
   parameter int PAGES = 8,
   parameter int COLS  = 128
) (
   input  wire logic                       MCLK,
   input  wire logic                       ARST_N,
   input  wire logic                       HARDWARE_RESET_N,
   input  wire logic                       PARALLEL_SELECT,
   input  wire logic                       BUS_STYLE_SELECT,
   input  wire logic                       CHIP_SELECT_N,
   input  wire logic                       CMD_DATA_SELECT,
   input  wire logic                       RD_N,
   input  wire logic                       WR_N,
   input  wire logic [7:0]                 DATA_IN,
   output logic      [7:0]                 DATA_OUT,
   output logic                            DATA_OE,
   input  wire logic [$clog2(PAGES)-1:0]   SCAN_PAGE,
   input  wire logic [7:0]                 SCAN_COL,
   output logic      [7:0]                 SCAN_DOTS,
   output logic                            DISPLAY_ON,
   output logic      [5:0]                 START_LINE,
   output logic      [3:0]                 PAGE_ADDR,
   output logic      [7:0]                 COLUMN_ADDR,
   output logic                            SEG_REVERSE,
   output logic                            INVERT,
   output logic                            ALL_ON,
   output logic                            BIAS_SEVENTH,
   output logic                            RMW_ACTIVE,
   output logic                            COM_REVERSE,
   output logic      [2:0]                 POWER_MODE,
   output logic      [2:0]                 REG_RATIO,
   output logic      [5:0]                 VOLUME,
   output logic                            STATIC_ON,
   output logic                            STATIC_FLASH,
   output logic      [1:0]                 BOOSTER,
   output logic                            POWER_SAVE,
   output logic                            RESET_BUSY
);

   localparam int AW      = $clog2(PAGES * COLS);
   localparam int RST_WIN = int'(RESET_MAX_CYC);

   logic [PIN_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
   logic             wr_act_reg, rd_act_reg, cs_prev_reg;
   logic             wr_act, rd_act, hw_rst, cs_n, sel_data, par;
   logic             cmd_wr, data_wr, cmd_rd, data_rd, cmd_idle;
   logic [7:0]       bus_byte, col_save_reg;
   logic [AW-1:0]    host_idx, scan_idx;
   logic             host_ok, scan_ok;
   lcdd_pend_type    pend_reg;
   logic [7:0]       ram [0:PAGES*COLS-1];
   logic [7:0]       scan_raw;

   // Three-stage synchroniser; a bit changes only when stages two and three agree
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync1_reg <= PIN_RST;
         sync2_reg <= PIN_RST;
         sync3_reg <= PIN_RST;
         pin_reg   <= PIN_RST;
      end else begin
         sync1_reg <= {PARALLEL_SELECT, HARDWARE_RESET_N, BUS_STYLE_SELECT, CHIP_SELECT_N,
                       CMD_DATA_SELECT, RD_N, WR_N, DATA_IN};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg   <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
      end
   end

   always_comb begin
      par      = pin_reg[14];
      hw_rst   = ~pin_reg[13];
      cs_n     = pin_reg[11];
      sel_data = pin_reg[10];
      bus_byte = pin_reg[7:0];
      // 6800 style: RD_N carries the high-active enable, WR_N the read/write level
      if (pin_reg[12]) begin
         wr_act = pin_reg[9] & ~pin_reg[8];
         rd_act = pin_reg[9] & pin_reg[8];
      end else begin
         wr_act = ~pin_reg[8];
         rd_act = ~pin_reg[9];
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_act_reg  <= 1'b0;
         rd_act_reg  <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         wr_act_reg  <= wr_act;
         rd_act_reg  <= rd_act;
         cs_prev_reg <= cs_n;
      end
   end

   always_comb begin
      // Writes take the byte at the end of the strobe (see R26)
      cmd_wr   = wr_act_reg & ~wr_act & ~cs_prev_reg & ~sel_data & ~hw_rst;   // see R24
      data_wr  = wr_act_reg & ~wr_act & ~cs_prev_reg & sel_data & ~hw_rst;
      // Reads answer at the start of the strobe, parallel mode only (see R27)
      cmd_rd   = rd_act & ~rd_act_reg & ~cs_n & ~sel_data & par & ~hw_rst;
      data_rd  = rd_act & ~rd_act_reg & ~cs_n & sel_data & par & ~hw_rst;
      cmd_idle = cmd_wr & (pend_reg == ST_IDLE);
      host_ok  = (PAGE_ADDR < PAGES) && (COLUMN_ADDR < COLS);
      host_idx = AW'(PAGE_ADDR * COLS + COLUMN_ADDR);
      scan_ok  = (SCAN_PAGE < PAGES) && (SCAN_COL < COLS);
      // Reversed segment mapping reads columns from the far end (see R8)
      scan_idx = AW'(SCAN_PAGE * COLS + (SEG_REVERSE ? COLS - 1 - SCAN_COL : SCAN_COL));
      scan_raw = scan_ok ? ram[scan_idx] : 8'h00;
   end

   // Second byte of a two-byte command
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_reg <= ST_IDLE;
      end else if (hw_rst) begin
         pend_reg <= ST_IDLE;
      end else if (cmd_wr) begin
         unique case (pend_reg)
            ST_IDLE: begin
               if (bus_byte == CMD_VOLUME) begin
                  pend_reg <= ST_VOLUME;                                   // see R16
               end else if ((bus_byte & MASK_BIT0) == CMD_STATIC) begin
                  pend_reg <= ST_STATIC;                                   // see R17
               end else if (bus_byte == CMD_BOOSTER) begin
                  pend_reg <= ST_BOOSTER;                                  // see R18
               end
            end
            ST_VOLUME, ST_STATIC, ST_BOOSTER: begin
               pend_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Display mode flags; cleared by the hardware reset only (see R25)
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         DISPLAY_ON   <= 1'b0;
         SEG_REVERSE  <= 1'b0;
         INVERT       <= 1'b0;
         ALL_ON       <= 1'b0;
         BIAS_SEVENTH <= 1'b0;
      end else if (hw_rst) begin
         DISPLAY_ON   <= 1'b0;
         SEG_REVERSE  <= 1'b0;
         INVERT       <= 1'b0;
         ALL_ON       <= 1'b0;
         BIAS_SEVENTH <= 1'b0;
      end else if (cmd_idle) begin
         unique case (bus_byte & MASK_BIT0)
            CMD_DISPLAY: DISPLAY_ON   <= bus_byte[0];                      // see R1
            CMD_SEG_DIR: SEG_REVERSE  <= bus_byte[0];                      // see R8
            CMD_INVERT:  INVERT       <= bus_byte[0];                      // see R9
            CMD_ALL_ON:  ALL_ON       <= bus_byte[0];                      // see R10
            CMD_BIAS:    BIAS_SEVENTH <= bus_byte[0];                      // see R11
            default: ;
         endcase
      end
   end

   // Settings that the software reset also clears
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         START_LINE  <= RST_START;
         COM_REVERSE <= 1'b0;
         POWER_MODE  <= RST_POWER;
         REG_RATIO   <= RST_RATIO;
         VOLUME      <= RST_VOLUME;
         STATIC_ON   <= 1'b0;
         STATIC_FLASH <= 1'b0;
         BOOSTER     <= RST_BOOSTER;
      end else if (hw_rst || (cmd_idle && bus_byte == CMD_SW_RESET)) begin
         START_LINE  <= RST_START;
         COM_REVERSE <= 1'b0;
         POWER_MODE  <= RST_POWER;
         REG_RATIO   <= RST_RATIO;
         VOLUME      <= RST_VOLUME;
         STATIC_ON   <= 1'b0;
         STATIC_FLASH <= 1'b0;
         BOOSTER     <= RST_BOOSTER;
      end else if (cmd_wr && pend_reg == ST_VOLUME) begin
         VOLUME <= bus_byte[5:0];                                          // see R16
      end else if (cmd_wr && pend_reg == ST_STATIC) begin
         STATIC_FLASH <= bus_byte[0];                                      // see R17
      end else if (cmd_wr && pend_reg == ST_BOOSTER) begin
         BOOSTER <= bus_byte[1:0];                                         // see R18
      end else if (cmd_idle) begin
         if ((bus_byte & MASK_TOP2) == CMD_START_LINE) begin
            START_LINE <= bus_byte[5:0];                                   // see R2
         end
         if ((bus_byte & MASK_TOP4) == CMD_COM_DIR) begin
            COM_REVERSE <= bus_byte[3];                                    // see R13
         end
         if ((bus_byte & MASK_TOP5) == CMD_POWER) begin
            POWER_MODE <= bus_byte[2:0];                                   // see R14
         end
         if ((bus_byte & MASK_TOP5) == CMD_RATIO) begin
            REG_RATIO <= bus_byte[2:0];                                    // see R15
         end
         if ((bus_byte & MASK_BIT0) == CMD_STATIC) begin
            STATIC_ON <= bus_byte[0];                                      // see R17
         end
      end
   end

   // Page and column pointers with read-modify-write; NOP falls through untouched
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PAGE_ADDR    <= RST_PAGE;
         COLUMN_ADDR  <= RST_COLUMN;
         RMW_ACTIVE   <= 1'b0;
         col_save_reg <= RST_COLUMN;
      end else if (hw_rst || (cmd_idle && bus_byte == CMD_SW_RESET)) begin
         PAGE_ADDR    <= RST_PAGE;
         COLUMN_ADDR  <= RST_COLUMN;
         RMW_ACTIVE   <= 1'b0;
         col_save_reg <= RST_COLUMN;
      end else if (cmd_idle) begin                                         // see R23
         if ((bus_byte & MASK_TOP4) == CMD_PAGE) begin
            PAGE_ADDR <= bus_byte[3:0];                                    // see R3
         end else if ((bus_byte & MASK_TOP4) == CMD_COL_HIGH) begin
            COLUMN_ADDR[7:4] <= bus_byte[3:0];                             // see R4
         end else if ((bus_byte & MASK_TOP4) == CMD_COL_LOW) begin
            COLUMN_ADDR[3:0] <= bus_byte[3:0];                             // see R4
         end else if (bus_byte == CMD_RMW) begin
            RMW_ACTIVE   <= 1'b1;                                          // see R12
            col_save_reg <= COLUMN_ADDR;
         end else if (bus_byte == CMD_END) begin
            // End returns the column to where the edit began
            RMW_ACTIVE  <= 1'b0;                                           // see R12
            COLUMN_ADDR <= col_save_reg;
         end
      end else if (data_wr || (data_rd && !RMW_ACTIVE)) begin
         COLUMN_ADDR <= COLUMN_ADDR + 8'h01;                               // see R12
      end
   end

   // Display RAM keeps its contents across resets
   always_ff @(posedge MCLK) begin
      if (data_wr && host_ok) begin
         ram[host_idx] <= bus_byte;                                        // see R6
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         DATA_OUT <= 8'h00;
         DATA_OE  <= 1'b0;
      end else begin
         DATA_OE <= rd_act & ~cs_n & par & ~hw_rst;
         if (cmd_rd) begin
            DATA_OUT <= 8'h00;                                             // see R5
            DATA_OUT[STAT_SEG_BIT] <= SEG_REVERSE;
            DATA_OUT[STAT_OFF_BIT] <= ~DISPLAY_ON;
            DATA_OUT[STAT_RST_BIT] <= RESET_BUSY;
         end else if (data_rd) begin
            DATA_OUT <= host_ok ? ram[host_idx] : 8'h00;                   // see R7
         end
      end
   end

   // Panel dot path: off blanks, all-on overrides RAM, then inversion
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SCAN_DOTS <= 8'h00;
      end else if (!DISPLAY_ON) begin
         SCAN_DOTS <= 8'h00;                                               // see R1
      end else if (ALL_ON) begin
         SCAN_DOTS <= 8'hff;                                               // see R10
      end else begin
         SCAN_DOTS <= INVERT ? ~scan_raw : scan_raw;                       // see R9
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         POWER_SAVE <= 1'b0;
         RESET_BUSY <= 1'b1;
      end else begin
         POWER_SAVE <= ~DISPLAY_ON & ALL_ON;                               // see R19
         // Busy for one cycle past the reset, well inside the 1 us budget
         RESET_BUSY <= hw_rst | (cmd_idle && bus_byte == CMD_SW_RESET);    // see R22
      end
   end

   sequence vol_cmd_seq;
      cmd_idle && bus_byte == CMD_VOLUME;
   endsequence

   sequence vol_arg_seq;
      cmd_wr && pend_reg == ST_VOLUME;
   endsequence

   property vol_prop;
      @(posedge MCLK) disable iff (!ARST_N)
      vol_arg_seq |=> VOLUME == $past(bus_byte[5:0]);
   endproperty

   AST_DISPLAY: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R1
      cmd_idle && (bus_byte & MASK_BIT0) == CMD_DISPLAY |=> DISPLAY_ON == $past(bus_byte[0]))
      else $error("display on/off not taken");
   AST_START_LINE: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R2
      cmd_idle && bus_byte[7:6] == 2'b01 |=> START_LINE == $past(bus_byte[5:0]))
      else $error("start line not loaded");
   AST_PAGE: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R3
      cmd_idle && bus_byte[7:4] == 4'hb |=> PAGE_ADDR == $past(bus_byte[3:0]))
      else $error("page pointer not loaded");
   AST_COL_HIGH: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R4
      cmd_idle && bus_byte[7:4] == 4'h1 |=> COLUMN_ADDR[7:4] == $past(bus_byte[3:0])
      && $stable(COLUMN_ADDR[3:0]))
      else $error("column high nibble wrong");
   AST_STATUS: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R5
      cmd_rd |=> DATA_OUT[3:0] == 4'h0 && DATA_OUT[STAT_OFF_BIT] == !$past(DISPLAY_ON))
      else $error("status byte malformed");
   AST_RMW_READ: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R12
      data_rd && RMW_ACTIVE |=> $stable(COLUMN_ADDR))
      else $error("column moved on read in read-modify-write");
   AST_WRITE_STEP: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R6
      data_wr |=> COLUMN_ADDR == $past(COLUMN_ADDR) + 8'h01)
      else $error("column did not advance after data write");
   AST_VOLUME: assert property (vol_prop) // see R16
      else $error("volume value not stored");
   // The pending argument state is entered in the cycle after the volume command
   AST_VOL_PEND: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R16
      vol_cmd_seq |=> pend_reg == ST_VOLUME)
      else $error("volume argument not awaited");
   AST_SERIAL_READ: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R27
      !par |=> !DATA_OE)
      else $error("read answered in serial mode");
   AST_NOP: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R23
      cmd_idle && bus_byte == CMD_NOP |=> $stable(COLUMN_ADDR) && $stable(PAGE_ADDR)
      && $stable(VOLUME) && $stable(DISPLAY_ON))
      else $error("no-operation changed state");
   AST_HW_RESET: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R25
      hw_rst |=> !DISPLAY_ON && COLUMN_ADDR == RST_COLUMN && pend_reg == ST_IDLE)
      else $error("hardware reset did not clear settings");
   AST_RESET_TIME: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R22
      $fell(hw_rst) |-> ##[0:RST_WIN] !RESET_BUSY)
      else $error("internal reset too long");
   AST_POWER_SAVE: assert property (@(posedge MCLK) disable iff (!ARST_N) // see R19
      !DISPLAY_ON && ALL_ON ##1 !DISPLAY_ON && ALL_ON |-> POWER_SAVE)
      else $error("power save not entered");

endmodule

// File: lcdd_host.sv
// Host processor model that drives the parallel bus in 8080 or 6800 style
`timescale 1ns/1ns
module lcdd_host (
   input  wire logic       mclk,
   output logic            cs_n,
   output logic            dc,
   output logic            rd_n,
   output logic            wr_n,
   output logic [7:0]      dq
);
   initial {cs_n, dc, rd_n, wr_n, dq} = 12'hb00;
   // One strobe cycle; every phase is held for at least four clocks
   // In 6800 style rd_n carries the enable and wr_n the read/write level
   task automatic access(input logic s, input logic [7:0] b, input logic rd,
                         input logic m68 = 1'b0);
      @(negedge mclk);
      {cs_n, dc, dq} = {1'b0, s, b};
      if (m68)
         {rd_n, wr_n} = {1'b0, rd};
      repeat (4) @(negedge mclk);
      if (m68)
         rd_n = 1'b1;
      else if (rd)
         rd_n = 1'b0;
      else
         wr_n = 1'b0;
      repeat (5) @(negedge mclk);
      if (m68)
         rd_n = 1'b0;
      else
         {rd_n, wr_n} = 2'h3;  // Data held past the rising edge
      repeat (4) @(negedge mclk);
      // Released bus shows the inverse so that a stale byte cannot match
      {cs_n, dq} = {1'b1, ~b};
      repeat (4) @(negedge mclk);
   endtask
endmodule

// File: lcdd_decoder_tb.sv
// Self-checking bench of the LCD command decoder
`timescale 1ns/1ns
module lcdd_decoder_tb
   import lcdd_pkg::*;
;
   logic        mclk, arst_n, hw_n, cs_n, dc, rd_n, wr_n, par, sty;
   logic [7:0]  dq, d, c, sc;
   logic [2:0]  p, sp;
   logic [31:0] r;
   logic [7:0]  fld [19];
   logic [12:0] sq [$];
   logic [7:0]  rq [$];
   int          fail_count, checks_done;
   logic [7:0]  bv [3] = '{8'h01, 8'h03, 8'h00};
   logic [7:0]  init_seq [14] = '{8'he2, 8'ha3, 8'ha0, 8'hc8, 8'h25, 8'h81, 8'h13,
      8'h25, 8'h40, 8'hb0, 8'h10, 8'h04, 8'ha4, 8'ha6};
   // Command, field index, expected value
   logic [23:0] mt [11] = '{24'ha1_0401, 24'ha7_0501, 24'ha5_0601, 24'ha2_0700,
      24'hcf_0901, 24'h2b_0a03, 24'h22_0b02, 24'ha0_0400, 24'ha6_0500, 24'ha4_0600,
      24'hc7_0900};
   lcdd_host host (.mclk(mclk), .cs_n(cs_n), .dc(dc), .rd_n(rd_n), .wr_n(wr_n), .dq(dq));
   lcdd_decoder dut (.MCLK(mclk), .ARST_N(arst_n), .HARDWARE_RESET_N(hw_n),
      .PARALLEL_SELECT(par), .BUS_STYLE_SELECT(sty), .CHIP_SELECT_N(cs_n),
      .CMD_DATA_SELECT(dc), .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(dq), .DATA_OUT(),
      .DATA_OE(), .SCAN_PAGE(sp), .SCAN_COL(sc), .SCAN_DOTS(), .DISPLAY_ON(),
      .START_LINE(), .PAGE_ADDR(), .COLUMN_ADDR(), .SEG_REVERSE(), .INVERT(), .ALL_ON(),
      .BIAS_SEVENTH(), .RMW_ACTIVE(), .COM_REVERSE(), .POWER_MODE(), .REG_RATIO(),
      .VOLUME(), .STATIC_ON(), .STATIC_FLASH(), .BOOSTER(), .POWER_SAVE(), .RESET_BUSY());
   assign fld = '{8'(dut.DISPLAY_ON), 8'(dut.START_LINE), 8'(dut.PAGE_ADDR), dut.COLUMN_ADDR,
      8'(dut.SEG_REVERSE), 8'(dut.INVERT), 8'(dut.ALL_ON), 8'(dut.BIAS_SEVENTH),
      8'(dut.RMW_ACTIVE), 8'(dut.COM_REVERSE), 8'(dut.POWER_MODE), 8'(dut.REG_RATIO),
      8'(dut.VOLUME), 8'(dut.STATIC_ON), 8'(dut.STATIC_FLASH), 8'(dut.BOOSTER),
      8'(dut.POWER_SAVE), dut.SCAN_DOTS, 8'(dut.RESET_BUSY)};
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] b, input logic s = 1'b0, input logic m = 1'b0);
      host.access(s, b, 1'b0, m);
   endtask
   task automatic rd(input logic s, input logic [7:0] e, input logic m = 1'b0);
      rq.push_back(e);
      host.access(s, ~e, 1'b1, m);
   endtask
   task automatic col(input logic [7:0] v);
      wr({4'h1, v[7:4]});
      wr({4'h0, v[3:0]});
   endtask
   task automatic note(input logic [4:0] i, input logic [7:0] v);
      sq.push_back({i, v});
   endtask
   task automatic wrap_up();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Settings are only noted once settled, so the next falling edge may compare
   always @(negedge mclk)
      while (sq.size() > 0) begin
         check(fld[sq[0][12:8]], sq[0][7:0]);
         sq.delete(0);
      end
   always @(posedge dut.DATA_OE) begin
      @(negedge mclk);
      check(dut.DATA_OUT, rq[0]);
      rq.delete(0);
   end
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #500000;
      fail_count++;
      wrap_up();
   end
   initial begin
      {arst_n, hw_n, par, sty, sp, sc} = {1'b0, 1'b1, 1'b1, 1'b0, 11'h000};
      void'($urandom(32'h31fe));
      r = $urandom;
      d = r[31:24];
      p = r[22:20];
      c = {1'b0, r[6:1], 1'b0};
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      repeat (10) @(negedge mclk);
      foreach (init_seq[i]) wr(init_seq[i]);  // Suggested start-up
      note(7, 8'h01);
      note(9, 8'h01);
      note(11, 8'h05);
      note(12, 8'h13);
      note(3, 8'h04);
      wr(8'haf);
      note(0, 8'h01);
      wr({2'h1, r[5:0]});
      note(1, {2'h0, r[5:0]});
      wr({4'hb, r[11:8]});
      note(2, {4'h0, r[11:8]});
      col(r[19:12]);
      note(3, r[19:12]);
      wr(CMD_NOP);
      note(3, r[19:12]);
      foreach (mt[i]) begin  // Mode bits
         wr(mt[i][23:16]);
         note(mt[i][12:8], mt[i][7:0]);
      end
      wr(CMD_VOLUME);
      // Argument looks like a scan direction command, so a misread would show
      wr({4'hc, 1'b1, r[26:24]});
      note(12, {4'h0, 1'b1, r[26:24]});
      note(9, 8'h00);  // Argument is not a command
      wr(8'had);
      wr(8'h01);
      note(13, 8'h01);
      note(14, 8'h01);
      foreach (bv[i]) begin
         wr(CMD_BOOSTER);  // Only allowed upper code
         wr(bv[i]);
         note(15, bv[i]);
      end
      wr(8'hae);
      wr(8'ha5);
      note(16, 8'h01);
      wr(8'ha4);
      wr(8'haf);
      note(16, 8'h00);
      {sp, sc} = {p, c};
      wr({5'h16, p});
      col(c);
      wr(d, 1'b1);
      note(3, c + 8'h01);
      note(17, d);
      wr(8'ha7);
      note(17, ~d);
      wr(8'ha5);
      note(17, 8'hff);
      wr(8'ha4);
      wr(8'ha6);
      col(c);
      rd(1'b1, d);
      note(3, c + 8'h01);
      wr(8'ha1);
      sc = 8'h7f - c;
      @(negedge mclk);
      note(17, d);  // Far-end column shows the written byte
      rd(1'b0, 8'h40);
      wr(8'hae);
      rd(1'b0, 8'h60);
      wr(8'haf);
      wr(8'ha0);
      col(c);
      wr(CMD_RMW);
      note(8, 8'h01);
      rd(1'b1, d);
      note(3, c);  // Read holds column
      wr(~d, 1'b1);
      note(3, c + 8'h01);
      wr(CMD_END);
      note(8, 8'h00);
      note(3, c);
      rd(1'b1, ~d);
      par = 1'b0;
      host.access(1'b1, 8'h00, 1'b1);  // No answer expected in serial mode
      note(3, c + 8'h01);  // Refused read leaves the column
      par = 1'b1;
      sty = 1'b1;
      wr(8'h55, 1'b0, 1'b1);
      note(1, 8'h15);  // 6800 write taken at enable fall
      rd(1'b0, 8'h00, 1'b1);  // 6800 status read
      hw_n = 1'b0;
      repeat (10) @(negedge mclk);  // Pulse of 1 us
      note(0, 8'h00);
      note(3, 8'h00);
      note(12, 8'h00);
      note(18, 8'h01);
      hw_n = 1'b1;
      repeat (10) @(negedge mclk);
      note(18, 8'h00);  // Done within 1 us
      repeat (2) @(negedge mclk);
      check(8'(rq.size()), 8'h00);  // Every read answered
      wrap_up();
   end
endmodule
